//--- bridge_channel.sv
// One half-bridge: role classification, pre-phase currents, free-wheel and post-charge.
`timescale 1ns/1ps
`default_nettype none
module bridge_channel
  import gate_seq_pkg::*;
(
  // Clock and reset
  input  wire logic          clock_i,
  input  wire logic          nrst_i,
  // Shared settings
  bridge_tick_if.dst         cfg,
  // Per-bridge control
  input  wire logic          pwm_i,
  input  wire logic          high_side_pwm_i,
  input  wire logic          freewheel_en_i,
  input  wire logic          above_upper_i,
  input  wire logic          below_lower_i,
  input  wire logic [5:0]    max_code_i,
  input  wire logic [5:0]    pchg_init_i,
  input  wire logic [5:0]    pdchg_init_i,
  input  wire logic [5:0]    chg_code_i,
  input  wire logic [7:0]    pchg_dur_i,
  input  wire logic [7:0]    pdchg_dur_i,
  input  wire logic          early_on_i,
  input  wire logic          late_on_i,
  // Gate outputs
  output logic               hs_on_o,
  output logic               ls_on_o,
  output logic               hs_active_o,
  output logic               ccp_active_o,
  output logic               pre_active_o,
  output logic [5:0]         drive_code_o,
  output logic [5:0]         pre_code_o,
  output logic [5:0]         sink_code_o
);
  import gate_seq_pkg::*;

  logic       pwm_q, pwm_d;
  logic       hs_act_q, hs_act_d;
  logic       hs_q, hs_d, ls_q, ls_d;
  logic       ccp_q, ccp_d;
  logic [5:0] pch_q, pch_d, pdch_q, pdch_d;
  logic [5:0] drv_q, drv_d;
  logic [7:0] cnt_q, cnt_d;
  logic       on_edge_q, on_edge_d;
  phase_e     ph_q, ph_d;
  logic       seeded_q, seeded_d;
  logic [5:0] pch_base, pdch_base;

  function automatic logic [5:0] clamp_up(input logic [5:0] v, input logic [5:0] mx);
    clamp_up = (v >= mx) ? mx : v + ADAPT_STEP;
  endfunction

  function automatic logic [5:0] clamp_dn(input logic [5:0] v, input logic [5:0] mx);
    logic [5:0] t;
    t = (v <= CODE_MIN) ? CODE_MIN : v - ADAPT_STEP;
    clamp_dn = (t > mx) ? mx : t;
  endfunction

  always_comb begin
    pwm_d     = pwm_i;
    hs_act_d  = hs_act_q;
    pch_d     = pch_q;
    pdch_d    = pdch_q;
    drv_d     = drv_q;
    cnt_d     = cnt_q;
    ph_d      = ph_q;
    ccp_d     = 1'b0;
    on_edge_d = on_edge_q;
    seeded_d  = seeded_q && cfg.gate_scheme_select[1];
    // Adaptation resumes from the stored codes only once seeded from the start values.
    pch_base  = seeded_q ? pch_q : pchg_init_i;
    pdch_base = seeded_q ? pdch_q : pdchg_init_i;
    // Role is decided on every switching edge, just before turn-on.
    if (pwm_i != pwm_q) begin
      on_edge_d = pwm_i;
      if (cfg.role_detect_enable) begin
        if (above_upper_i) hs_act_d = 1'b0;
        else if (below_lower_i) hs_act_d = 1'b1;
        else hs_act_d = high_side_pwm_i;
      end else begin
        hs_act_d = high_side_pwm_i;
      end
      // Self-adaptation of the pre-phase codes from the measured delay.
      if (!cfg.gate_scheme_select[1]) begin
        pch_d  = pchg_init_i;
        pdch_d = pdchg_init_i;
      end else begin
        seeded_d = 1'b1;
        pch_d    = pch_base;
        pdch_d   = pdch_base;
        // Only the active transistor's delays are regulated.
        if (hs_act_d == high_side_pwm_i) begin
          if (pwm_i) pch_d = late_on_i ? clamp_up(pch_base, max_code_i)
                                       : (early_on_i ? clamp_dn(pch_base, max_code_i) : pch_base);
          else pdch_d = late_on_i ? clamp_up(pdch_base, max_code_i)
                                  : (early_on_i ? clamp_dn(pdch_base, max_code_i) : pdch_base);
        end
      end
      cnt_d = pwm_i ? pchg_dur_i : pdchg_dur_i;
      // A pre-phase is only applied when the PWM transistor is the active one.
      ph_d  = (cfg.gate_scheme_select == SCHEME_OFF || hs_act_d != high_side_pwm_i) ? PH_MAIN : PH_PRE;
      ccp_d = freewheel_en_i;
      drv_d = chg_code_i;
    end else begin
      unique case (ph_q)
        PH_IDLE: ph_d = PH_IDLE;
        PH_PRE: begin
          if (cnt_q == 8'h00) ph_d = PH_MAIN;
          else cnt_d = cnt_q - 8'h01;
        end
        PH_MAIN: ph_d = (cfg.post_charge_disable || !on_edge_q) ? PH_HOLD : PH_POST;
        PH_POST: begin
          if (drv_q >= max_code_i) ph_d = PH_HOLD;
          else if (cfg.bd_tick) drv_d = drv_q + ADAPT_STEP;
        end
        PH_HOLD: ph_d = PH_HOLD;
      endcase
    end
  end

  always_comb begin
    // The PWM transistor follows pwm; the opposite one free-wheels actively only when freewheel_en_i is set, otherwise it stays off.
    hs_d = high_side_pwm_i ? pwm_q : (freewheel_en_i && !pwm_q);
    ls_d = high_side_pwm_i ? (freewheel_en_i && !pwm_q) : pwm_q;
    if (ccp_d) begin
      hs_d = 1'b0;
      ls_d = 1'b0;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pwm_q     <= 1'b0;
      hs_act_q  <= 1'b0;
      hs_q      <= 1'b0;
      ls_q      <= 1'b0;
      ccp_q     <= 1'b0;
      pch_q     <= CODE_RESET;
      pdch_q    <= CODE_RESET;
      drv_q     <= CODE_RESET;
      cnt_q     <= 8'h00;
      on_edge_q <= 1'b0;
      ph_q      <= PH_IDLE;
      seeded_q  <= 1'b0;
    end else begin
      pwm_q     <= pwm_d;
      hs_act_q  <= hs_act_d;
      hs_q      <= hs_d;
      ls_q      <= ls_d;
      ccp_q     <= ccp_d;
      pch_q     <= pch_d;
      pdch_q    <= pdch_d;
      drv_q     <= drv_d;
      cnt_q     <= cnt_d;
      on_edge_q <= on_edge_d;
      ph_q      <= ph_d;
      seeded_q  <= seeded_d;
    end
  end

  assign hs_on_o      = hs_q;
  assign ls_on_o      = ls_q;
  assign hs_active_o  = hs_act_q;
  assign ccp_active_o = ccp_q;
  assign pre_active_o = (ph_q == PH_PRE);
  assign drive_code_o = drv_q;
  assign pre_code_o   = on_edge_q ? pch_q : pdch_q;
  assign sink_code_o  = HARD_OFF_CODE;
endmodule
`default_nettype wire

//--- gate_seq_pkg.sv
// Shared constants and types for the half-bridge PWM gate sequencer.
`default_nettype none
package gate_seq_pkg;

  localparam int unsigned NUM_BRIDGES   = 3;
  localparam int unsigned CODE_W        = 6;
  localparam int unsigned TIME_W        = 8;
  localparam int unsigned PWM_INPUTS    = 6;

  // Lowest current step and the hard-off sink code.
  localparam logic [5:0] CODE_MIN       = 6'h00;
  localparam logic [5:0] HARD_OFF_CODE  = 6'h3f;
  localparam logic [5:0] CODE_RESET     = 6'h00;

  // Pre-phase adaptation: one code step per switching event.
  localparam logic [5:0] ADAPT_STEP     = 6'h01;

  // Gate scheme encodings.
  localparam logic [1:0] SCHEME_OFF     = 2'h0;
  localparam logic [1:0] SCHEME_FIXED   = 2'h1;

  // Bridge-driver clock divider: ticks every bridge_driver_clock_setting_i + 1 cycles of clock_i.
  localparam logic [3:0] BD_DIV_RESET   = 4'h4;

  // PWM input index driving each bridge with three inputs (inputs 0,2,4).
  localparam logic [2:0] PWM_SEL_BRIDGE0 = 3'h0;
  localparam logic [2:0] PWM_SEL_BRIDGE1 = 3'h2;
  localparam logic [2:0] PWM_SEL_BRIDGE2 = 3'h4;

  typedef enum logic [2:0] {
    PH_IDLE,
    PH_PRE,
    PH_MAIN,
    PH_POST,
    PH_HOLD
  } phase_e;

endpackage
`default_nettype wire

//--- bridge_tick_if.sv
// Interface carrying bridge-driver clock ticks and shared settings to each bridge.
`timescale 1ns/1ps
`default_nettype none
interface bridge_tick_if;
  logic       bd_tick;
  logic       role_detect_enable;
  logic [1:0] gate_scheme_select;
  logic       post_charge_disable;
  modport src (output bd_tick, output role_detect_enable, output gate_scheme_select, output post_charge_disable);
  modport dst (input bd_tick, input role_detect_enable, input gate_scheme_select, input post_charge_disable);
endinterface
`default_nettype wire

//--- half_bridge_pwm_gate_sequencer.sv
// Top of the three-bridge PWM gate sequencer.
`timescale 1ns/1ps
`default_nettype none
module half_bridge_pwm_gate_sequencer (
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        nrst_i,
  // Global configuration
  input  wire logic        role_detect_enable_i,
  input  wire logic [1:0]  gate_scheme_select_i,
  input  wire logic        post_charge_disable_i,
  input  wire logic        pwm_input_count_select_i,
  input  wire logic [3:0]  bridge_driver_clock_setting_i,
  // Per-bridge configuration
  input  wire logic [2:0]  active_freewheel_enable_i,
  input  wire logic [2:0]  bridge_pwm_select_i,
  input  wire logic [2:0]  high_side_pwm_i,
  input  wire logic [17:0] max_drive_code_i,
  input  wire logic [17:0] precharge_start_value_i,
  input  wire logic [17:0] predischarge_start_value_i,
  input  wire logic [17:0] charge_phase_current_i,
  input  wire logic [23:0] precharge_duration_i,
  input  wire logic [23:0] predischarge_duration_i,
  // Pins and analog status
  input  wire logic [5:0]  pwm_pin_i,
  input  wire logic [2:0]  phase_upper_threshold_i,
  input  wire logic [2:0]  phase_lower_threshold_i,
  input  wire logic [2:0]  turn_on_early_i,
  input  wire logic [2:0]  turn_on_late_i,
  // Gate control
  output logic [2:0]       hs_gate_on_o,
  output logic [2:0]       ls_gate_on_o,
  output logic [2:0]       hs_is_active_o,
  output logic [2:0]       crossconduction_gap_o,
  output logic [2:0]       pre_phase_o,
  output logic [17:0]      charge_code_o,
  output logic [17:0]      pre_phase_code_o,
  output logic [5:0]       forced_off_sink_current_o
);
  import gate_seq_pkg::*;

  bridge_tick_if tick_bus ();

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers; the first stage feeds only the second.
  logic [5:0] pwm_s1_q, pwm_s2_q;
  logic [2:0] up_s1_q, up_s2_q, lo_s1_q, lo_s2_q;
  logic [2:0] er_s1_q, er_s2_q, lt_s1_q, lt_s2_q;

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pwm_s1_q <= 6'h00;
      pwm_s2_q <= 6'h00;
      up_s1_q  <= 3'h0;
      up_s2_q  <= 3'h0;
      lo_s1_q  <= 3'h0;
      lo_s2_q  <= 3'h0;
      er_s1_q  <= 3'h0;
      er_s2_q  <= 3'h0;
      lt_s1_q  <= 3'h0;
      lt_s2_q  <= 3'h0;
    end else begin
      pwm_s1_q <= pwm_pin_i;
      pwm_s2_q <= pwm_s1_q;
      up_s1_q  <= phase_upper_threshold_i;
      up_s2_q  <= up_s1_q;
      lo_s1_q  <= phase_lower_threshold_i;
      lo_s2_q  <= lo_s1_q;
      er_s1_q  <= turn_on_early_i;
      er_s2_q  <= er_s1_q;
      lt_s1_q  <= turn_on_late_i;
      lt_s2_q  <= lt_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bridge-driver clock: a one-cycle tick from a programmable divider.
  logic [3:0] div_q, div_d;
  logic       tick_q, tick_d;

  always_comb begin
    tick_d = 1'b0;
    div_d  = div_q + 4'h1;
    if (div_q >= bridge_driver_clock_setting_i) begin
      div_d  = 4'h0;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div_q  <= 4'h0;
      tick_q <= 1'b0;
    end else begin
      div_q  <= div_d;
      tick_q <= tick_d;
    end
  end

  assign tick_bus.bd_tick             = tick_q;
  assign tick_bus.role_detect_enable  = role_detect_enable_i;
  assign tick_bus.gate_scheme_select  = gate_scheme_select_i;
  assign tick_bus.post_charge_disable = post_charge_disable_i;

  ////////////////////////////////////////////////////////////////////////////
  // Bridge channels.
  localparam logic [2:0] PWM_SEL [NUM_BRIDGES] = '{PWM_SEL_BRIDGE0, PWM_SEL_BRIDGE1, PWM_SEL_BRIDGE2};

  logic [2:0] hs_w, ls_w, act_w, ccp_w, pre_w;
  logic [17:0] drv_w, prc_w;
  logic [17:0] sink_w;

  genvar b;
  generate
    for (b = 0; b < NUM_BRIDGES; b++) begin : g_bridge
      logic pwm_b, freewheel_b;
      // Six-input mode is outside this block; the bridge then stays off.
      assign pwm_b = bridge_pwm_select_i[b] && !pwm_input_count_select_i
                   && pwm_s2_q[PWM_SEL[b]];
      assign freewheel_b = active_freewheel_enable_i[b] && bridge_pwm_select_i[b]
                   && !pwm_input_count_select_i;
      bridge_channel u_ch (
        .clock_i        (clock_i),
        .nrst_i         (nrst_i),
        .cfg            (tick_bus),
        .pwm_i          (pwm_b),
        .high_side_pwm_i(high_side_pwm_i[b]),
        .freewheel_en_i (freewheel_b),
        .above_upper_i  (up_s2_q[b]),
        .below_lower_i  (lo_s2_q[b]),
        .max_code_i     (max_drive_code_i[b*6 +: 6]),
        .pchg_init_i    (precharge_start_value_i[b*6 +: 6]),
        .pdchg_init_i   (predischarge_start_value_i[b*6 +: 6]),
        .chg_code_i     (charge_phase_current_i[b*6 +: 6]),
        .pchg_dur_i     (precharge_duration_i[b*8 +: 8]),
        .pdchg_dur_i    (predischarge_duration_i[b*8 +: 8]),
        .early_on_i     (er_s2_q[b]),
        .late_on_i      (lt_s2_q[b]),
        .hs_on_o        (hs_w[b]),
        .ls_on_o        (ls_w[b]),
        .hs_active_o    (act_w[b]),
        .ccp_active_o   (ccp_w[b]),
        .pre_active_o   (pre_w[b]),
        .drive_code_o   (drv_w[b*6 +: 6]),
        .pre_code_o     (prc_w[b*6 +: 6]),
        .sink_code_o    (sink_w[b*6 +: 6])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Output registers; every top output leaves from a flop.
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hs_gate_on_o              <= 3'h0;
      ls_gate_on_o              <= 3'h0;
      hs_is_active_o            <= 3'h0;
      crossconduction_gap_o     <= 3'h0;
      pre_phase_o               <= 3'h0;
      charge_code_o             <= 18'h00000;
      pre_phase_code_o          <= 18'h00000;
      forced_off_sink_current_o <= HARD_OFF_CODE;
    end else begin
      hs_gate_on_o              <= hs_w;
      ls_gate_on_o              <= ls_w;
      hs_is_active_o            <= act_w;
      crossconduction_gap_o     <= ccp_w;
      pre_phase_o               <= pre_w;
      charge_code_o             <= drv_w;
      pre_phase_code_o          <= prc_w;
      forced_off_sink_current_o <= sink_w[5:0];
    end
  end
endmodule
`default_nettype wire

//--- bridge_load_model.sv
// Behavioural power stage: three half-bridges, each with an inductive load on its phase node.
`timescale 1ns/1ps
`default_nettype none
module bridge_load_model (
  // Clock
  input  wire logic       clock_i,
  // Gate commands from the sequencer
  input  wire logic [2:0] hs_on_i,
  input  wire logic [2:0] ls_on_i,
  // Load state while both switches are off, and which transistors switch slowly
  input  wire logic [2:0] load_dir_i,
  input  wire logic [2:0] load_idle_i,
  input  wire logic [2:0] slow_i,
  // Comparator levels and switching-delay status
  output logic [2:0]      above_o,
  output logic [2:0]      below_o,
  output logic [2:0]      early_o,
  output logic [2:0]      late_o
);
  logic [11:0] hs_sh = 12'h000;
  logic [11:0] ls_sh = 12'h000;
  logic [2:0]  hs_v;
  logic [2:0]  ls_v;
  // A slow transistor lets the phase node follow its gate four cycles late instead of one.
  always @(posedge clock_i) begin
    hs_sh <= {hs_sh[8:0], hs_on_i};
    ls_sh <= {ls_sh[8:0], ls_on_i};
  end
  assign hs_v = (hs_sh[2:0] & ~slow_i) | (hs_sh[11:9] & slow_i);
  assign ls_v = (ls_sh[2:0] & ~slow_i) | (ls_sh[11:9] & slow_i);
  // With both switches off the load current picks a body diode, or the node floats in between.
  assign above_o = hs_v | (~hs_v & ~ls_v & ~load_idle_i & load_dir_i);
  assign below_o = ls_v | (~hs_v & ~ls_v & ~load_idle_i & ~load_dir_i);
  assign early_o = (hs_on_i & hs_v | ls_on_i & ls_v) & ~slow_i;
  assign late_o  = hs_on_i & ~hs_v | ls_on_i & ~ls_v;
endmodule
`default_nettype wire

//--- gate_seq_properties.sv
// Concurrent checks on the ports of the three-bridge gate sequencer.
`timescale 1ns/1ps
`default_nettype none
module gate_seq_properties
  import gate_seq_pkg::*;
(
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        nrst_i,
  // Configuration and pins
  input  wire logic        role_detect_enable_i,
  input  wire logic [1:0]  gate_scheme_select_i,
  input  wire logic        post_charge_disable_i,
  input  wire logic        pwm_input_count_select_i,
  input  wire logic [2:0]  active_freewheel_enable_i,
  input  wire logic [2:0]  bridge_pwm_select_i,
  input  wire logic [2:0]  high_side_pwm_i,
  input  wire logic [17:0] max_drive_code_i,
  input  wire logic [17:0] charge_phase_current_i,
  input  wire logic [5:0]  pwm_pin_i,
  // Outputs watched
  input  wire logic [2:0]  hs_gate_on_o,
  input  wire logic [2:0]  ls_gate_on_o,
  input  wire logic [2:0]  crossconduction_gap_o,
  input  wire logic [2:0]  pre_phase_o,
  input  wire logic [17:0] charge_code_o,
  input  wire logic [17:0] pre_phase_code_o,
  input  wire logic [5:0]  forced_off_sink_current_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!nrst_i);
  logic       ready0;
  logic [2:0] pre_ok;
  logic [2:0] chg_ok;
  assign ready0 = !pwm_input_count_select_i && bridge_pwm_select_i[0] && high_side_pwm_i[0]
                  && active_freewheel_enable_i[0] && !role_detect_enable_i;
  always_comb begin
    for (int b = 0; b < 3; b++) begin
      pre_ok[b] = !pre_phase_o[b] || pre_phase_code_o[b*6 +: 6] <= max_drive_code_i[b*6 +: 6];
      chg_ok[b] = charge_code_o[b*6 +: 6] <= max_drive_code_i[b*6 +: 6]
                  || charge_code_o[b*6 +: 6] <= charge_phase_current_i[b*6 +: 6];
    end
  end
  sequence rise0_s;
    $rose(pwm_pin_i[0]) ##1 (ready0 && pwm_pin_i[0]) [*8];
  endsequence
  sequence fall0_s;
    $fell(pwm_pin_i[0]) ##1 (ready0 && !pwm_pin_i[0]) [*8];
  endsequence
  sequence step_s;
    !post_charge_disable_i && charge_code_o[5:0] > $past(charge_code_o[5:0])
      && $past(charge_code_o[5:0]) >= charge_phase_current_i[5:0];
  endsequence
  sink_code_a: assert property (forced_off_sink_current_o == HARD_OFF_CODE)
    else $error("sink code differs from the hard-off code");
  six_input_off_a: assert property (pwm_input_count_select_i [*8] |-> (hs_gate_on_o | ls_gate_on_o) == 3'h0)
    else $error("gate driven in six-input mode");
  no_overlap_a: assert property ((hs_gate_on_o & ls_gate_on_o) == 3'h0)
    else $error("both switches of a bridge on");
  hs_follow_a: assert property (rise0_s |-> ##[0:600] (hs_gate_on_o[0] || !pwm_pin_i[0] || !ready0))
    else $error("high side did not follow its PWM input");
  fw_opposite_a: assert property (fall0_s |-> ##[0:600] (ls_gate_on_o[0] || pwm_pin_i[0] || !ready0))
    else $error("opposite switch not turned on while free-wheeling");
  gap_afw_a: assert property ($rose(crossconduction_gap_o[0]) |-> active_freewheel_enable_i[0])
    else $error("cross-conduction gap without free-wheel enable");
  scheme_off_a: assert property ((gate_scheme_select_i == SCHEME_OFF) [*8] |-> pre_phase_o == 3'h0)
    else $error("pre-phase seen with pre-phases off");
  pre_clamp_a: assert property (gate_scheme_select_i[1] |-> &pre_ok)
    else $error("adaptive pre-phase code above bridge maximum");
  charge_cap_a: assert property (&chg_ok)
    else $error("charge code ramped past bridge maximum");
  post_step_a: assert property (step_s |-> charge_code_o[5:0] == $past(charge_code_o[5:0]) + 6'h01)
    else $error("post-charge step larger than one");
  hold_charge_a: assert property ((post_charge_disable_i && $rose(hs_gate_on_o[0])) ##1 post_charge_disable_i [*8]
                                  |-> charge_code_o[5:0] <= charge_phase_current_i[5:0])
    else $error("charge code rose with post-charge disabled");
endmodule
`default_nettype wire

//--- test_half_bridge_pwm_gate_sequencer.sv
// Self-checking bench for the three-bridge PWM gate sequencer.
`timescale 1ns/1ps
`default_nettype none
module test_half_bridge_pwm_gate_sequencer;
  import gate_seq_pkg::*;
  logic        clock_i = 1'b0, nrst_i = 1'b0, role_detect_enable_i = 1'b0;
  logic        post_charge_disable_i = 1'b0, pwm_input_count_select_i = 1'b0, seen_pre, seen_gap;
  logic [1:0]  gate_scheme_select_i = 2'h0;
  logic [3:0]  bridge_driver_clock_setting_i = 4'h1;
  logic [2:0]  active_freewheel_enable_i = 3'h0, bridge_pwm_select_i = 3'h7, high_side_pwm_i = 3'h7;
  logic [2:0]  phase_upper_threshold_i, phase_lower_threshold_i, turn_on_early_i, turn_on_late_i;
  logic [2:0]  hs_gate_on_o, ls_gate_on_o, hs_is_active_o, crossconduction_gap_o, pre_phase_o;
  logic [2:0]  load_dir = 3'h0, load_idle = 3'h0, slow = 3'h0;
  logic [5:0]  pwm_pin_i = 6'h00, forced_off_sink_current_o, code, mx, chg, exp_g;
  logic [17:0] max_drive_code_i, precharge_start_value_i, predischarge_start_value_i, charge_phase_current_i;
  logic [17:0] charge_code_o, pre_phase_code_o;
  logic [23:0] precharge_duration_i, predischarge_duration_i;
  int          failures = 0, n_tests = 0, seed = 32'h55d0, k, i, b, d, n_adapt = 0;

  half_bridge_pwm_gate_sequencer uut (.clock_i, .nrst_i, .role_detect_enable_i, .gate_scheme_select_i,
    .post_charge_disable_i, .pwm_input_count_select_i, .bridge_driver_clock_setting_i, .active_freewheel_enable_i,
    .bridge_pwm_select_i, .high_side_pwm_i, .max_drive_code_i, .precharge_start_value_i,
    .predischarge_start_value_i, .charge_phase_current_i, .precharge_duration_i, .predischarge_duration_i,
    .pwm_pin_i, .phase_upper_threshold_i, .phase_lower_threshold_i, .turn_on_early_i, .turn_on_late_i,
    .hs_gate_on_o, .ls_gate_on_o, .hs_is_active_o, .crossconduction_gap_o, .pre_phase_o, .charge_code_o,
    .pre_phase_code_o, .forced_off_sink_current_o);
  bridge_load_model power_stage (.clock_i(clock_i), .hs_on_i(hs_gate_on_o), .ls_on_i(ls_gate_on_o),
    .load_dir_i(load_dir), .load_idle_i(load_idle), .slow_i(slow), .above_o(phase_upper_threshold_i),
    .below_o(phase_lower_threshold_i), .early_o(turn_on_early_i), .late_o(turn_on_late_i));

  always #5 clock_i = ~clock_i;

  task automatic check(input string what, input logic [17:0] exp, input logic [17:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Reference role of the high side at a rising edge; load 0 node low, 1 node high, 2 in between.
  function automatic logic hs_role(input logic detect, input int load);
    return !detect || load != 1;
  endfunction

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge clock_i);
    failures++;
    report_and_stop();
  end

  initial begin
    // Pre-phase durations of 2 to 9 cycles stay well below the 40-cycle observation window.
    for (i = 0; i < 3; i++) begin
      max_drive_code_i[i*6 +: 6] = 6'h20 | 6'($random(seed) & 'h1f);
      precharge_start_value_i[i*6 +: 6] = 6'($random(seed) & 'h1f);
      predischarge_start_value_i[i*6 +: 6] = 6'($random(seed) & 'h1f);
      charge_phase_current_i[i*6 +: 6] = 6'h01 + 6'($random(seed) & 'h0f);
      precharge_duration_i[i*8 +: 8] = 8'h02 + 8'($random(seed) & 'h07);
      predischarge_duration_i[i*8 +: 8] = 8'h02 + 8'($random(seed) & 'h07);
    end
    mx = max_drive_code_i[5:0];
    chg = charge_phase_current_i[5:0];
    repeat (3) @(negedge clock_i);
    check("reset flags", 15'h0, {hs_gate_on_o, ls_gate_on_o, hs_is_active_o, crossconduction_gap_o, pre_phase_o});
    check("reset codes", 18'h0, charge_code_o | pre_phase_code_o);
    check("sink code", HARD_OFF_CODE, forced_off_sink_current_o);
    nrst_i = 1'b1;
    // Role detection and pre-phase schemes on bridge 0 with passive free-wheeling.
    for (i = 0; i < 12; i++) begin
      gate_scheme_select_i = 2'(i % 4);
      role_detect_enable_i = (i >= 6);
      load_idle[0] = (i % 3 == 2);
      load_dir[0] = (i % 3 == 1);
      slow[0] = i[0];
      repeat (4) @(negedge clock_i);
      pwm_pin_i[0] = 1'b1;
      seen_pre = 1'b0;
      seen_gap = 1'b0;
      code = 6'h00;
      for (k = 0; k < 40; k++) begin
        @(negedge clock_i);
        seen_gap |= crossconduction_gap_o[0];
        if (pre_phase_o[0] && !seen_pre) begin
          seen_pre = 1'b1;
          code = pre_phase_code_o[5:0];
        end
        if (k == 8) check("active role", hs_role(role_detect_enable_i, i % 3), hs_is_active_o[0]);
      end
      check("pre phase", gate_scheme_select_i != 2'h0 && hs_role(role_detect_enable_i, i % 3), seen_pre);
      check("gap without free-wheel", 1'b0, seen_gap);
      if (seen_pre && gate_scheme_select_i == SCHEME_FIXED) check("fixed code", precharge_start_value_i[5:0], code);
      n_adapt = gate_scheme_select_i[1] ? n_adapt + int'(seen_pre) : 0;
      d = int'(code) - int'(precharge_start_value_i[5:0]);
      if (seen_pre && gate_scheme_select_i[1]) check("adaptive code", 1'b1, d <= n_adapt && d >= -n_adapt);
      pwm_pin_i[0] = 1'b0;
      repeat (150) @(negedge clock_i);
    end
    $display("Role and scheme test done");
    // Post-charge ramp, then hold, with active free-wheeling on bridge 0.
    gate_scheme_select_i = SCHEME_OFF;
    role_detect_enable_i = 1'b0;
    active_freewheel_enable_i = 3'h1;
    for (i = 0; i < 2; i++) begin
      post_charge_disable_i = i[0];
      repeat (4) @(negedge clock_i);
      pwm_pin_i[0] = 1'b1;
      for (k = 0; k < 300 && i == 0 && charge_code_o[5:0] !== mx; k++) @(negedge clock_i);
      if (i == 0) check("ramp time", 1'b1, k >= 2 * (int'(mx) - int'(chg)) - 1 && k < 300);
      repeat (100) @(negedge clock_i);
      check("charge code", i == 0 ? mx : chg, charge_code_o[5:0]);
      pwm_pin_i[0] = 1'b0;
      seen_gap = 1'b0;
      for (k = 0; k < 60; k++) begin
        @(negedge clock_i);
        seen_gap |= crossconduction_gap_o[0];
      end
      check("gap with free-wheel", 1'b1, seen_gap);
      check("free-wheel gates", 2'h1, {hs_gate_on_o[0], ls_gate_on_o[0]});
      repeat (200) @(negedge clock_i);
    end
    $display("Post-charge test done");
    // Input-to-bridge mapping, with random bridge selects and PWM sides.
    active_freewheel_enable_i = 3'h0;
    for (i = 0; i < 12; i++) begin
      bridge_pwm_select_i = 3'($random(seed));
      high_side_pwm_i = 3'($random(seed));
      pwm_input_count_select_i = (i >= 6);
      repeat (4) @(negedge clock_i);
      pwm_pin_i = 6'h01 << (i % 6);
      repeat (20) @(negedge clock_i);
      b = (i % 6) / 2;
      exp_g = 6'h00;
      if (i % 2 == 0 && bridge_pwm_select_i[b] && !pwm_input_count_select_i) exp_g[high_side_pwm_i[b] ? b + 3 : b] = 1'b1;
      check("mapped gates", exp_g, {hs_gate_on_o, ls_gate_on_o});
      pwm_pin_i = 6'h00;
      repeat (40) @(negedge clock_i);
    end
    $display("Mapping test done");
    report_and_stop();
  end
endmodule
bind half_bridge_pwm_gate_sequencer gate_seq_properties chk (.clock_i, .nrst_i, .role_detect_enable_i,
  .gate_scheme_select_i, .post_charge_disable_i, .pwm_input_count_select_i, .active_freewheel_enable_i,
  .bridge_pwm_select_i, .high_side_pwm_i, .max_drive_code_i, .charge_phase_current_i, .pwm_pin_i,
  .hs_gate_on_o, .ls_gate_on_o, .crossconduction_gap_o, .pre_phase_o, .charge_code_o, .pre_phase_code_o,
  .forced_off_sink_current_o);
`default_nettype wire
